// [hdl/fbsm_params.svh]
// Register indices, field positions and reset values of the slot mapper
`ifndef FBSM_PARAMS_SVH
`define FBSM_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define FBSM_IN_MAP_IDX 16'hf300
`define FBSM_OUT_MAP_IDX 16'hf380
`define FBSM_CTRL_IDX 16'hf3c0
`define FBSM_STAT_IDX 16'hf3c1
`define FBSM_CHAN_IDX 16'hf3d0
`define FBSM_MAP_MASK 16'hffc0
`define FBSM_CHAN_MASK 16'hfff0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FBSM_HIZ_A_BIT 0
`define FBSM_HIZ_B_BIT 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FBSM_MAP_RST 8'h00
`define FBSM_CTRL_RST 2'h0
`define FBSM_CNT_RST 9'h000

`endif

// [hdl/fbsm_pkg.sv]
// Types shared by the slot mapper and its bench
package fbsm_pkg;
    // One mapping entry, low byte of the 16-bit register
    typedef struct packed {
        logic en;
        logic rev;
        logic grp;
        logic [2:0] pos;
        logic [1:0] lane;
    } fbsm_map_s;

    // One serial output pin: data and output enable
    typedef struct packed {
        logic dout;
        logic oe;
    } fbsm_pin_s;

    // Sixteen 32-bit audio channels
    typedef logic [15:0][31:0] fbsm_chan_t;
endpackage

// [hdl/fbsm_slot_mapper.sv]
// Flexible TDM byte slot mapper with APB register access
// Summary of operation
// RULE_01: Three position bits pick channel 0 to 7 within the group.
// RULE_02: Input lane code 00 writes bits 31..24, up to 11 for 7..0.
// RULE_03: Each input channel is built from four separately written bytes.
// RULE_04: Sixty-four output mapping entries, one per output slot.
// RULE_05: Slots 0-31 go out on pin a, slots 32-63 on pin b.
// RULE_06: Low six entry bits pick source channel and byte of a slot.
// RULE_07: Disabled slot with idle high-impedance set leaves pin undriven.
// RULE_08: Disabled slot with idle high-impedance clear drives pin low.
// RULE_09: Enabled slot sends its mapped data byte.
// RULE_10: Bit 6 set sends the byte LSB first, clear MSB first.
// RULE_11: Entry bits 15..8 are reserved and reset to zero.
// RULE_12: Pin select 0 feeds channels 32-39 from pin a, 1 40-47 from b.
// RULE_13: Disabled input slots never change channel data.
// RULE_14: Output group bit picks channels 32-39 or 40-47.
// RULE_15: Output lane code 00 sends bits 31..24, up to 11 for 7..0.
// RULE_16: Software writes zero to reserved bits and expects zero back.
`include "fbsm_params.svh"

module fbsm_slot_mapper (
    input wire logic pclk, // APB and frame clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic [17:0] paddr, // APB byte address
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic bit_tick, // One serial bit time
    input wire logic frame_sync, // First bit of a frame
    input wire logic serial_in_pin_a, // Input stream a
    input wire logic serial_in_pin_b, // Input stream b
    input wire fbsm_pkg::fbsm_chan_t out_chan, // Channels 32-47 to send
    output fbsm_pkg::fbsm_chan_t in_chan, // Channels 32-47 received
    output fbsm_pkg::fbsm_pin_s serial_out_pin_a, // Output pin a
    output fbsm_pkg::fbsm_pin_s serial_out_pin_b // Output pin b
);
    import fbsm_pkg::*;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Mirror a byte end for end
    function automatic logic [7:0] rev8(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7-i];
        end
        return r;
    endfunction

    // Byte of a word by lane code, lane 0 is the top byte
    function automatic logic [7:0] lane_of(input logic [31:0] w,
                                           input logic [1:0] l);
        return w[{~l, 3'b000} +: 8];
    endfunction

    // Channel number within 32-47 from group and position
    function automatic logic [3:0] chan_of(input fbsm_map_s m);
        return {m.grp, m.pos};
    endfunction

    // Pin value for one bit of one output slot
    function automatic fbsm_pin_s pin_of(input fbsm_map_s m,
                                         input logic act,
                                         input logic hiz,
                                         input logic [7:0] b,
                                         input logic [2:0] k);
        fbsm_pin_s p;
        p.dout = 1'b0;
        p.oe = 1'b0;
        if (act && m.en) begin
            p.oe = 1'b1;
            p.dout = m.rev ? b[k] : b[~k];
        end else begin
            p.oe = ~hiz;
        end
        return p;
    endfunction

    // ------------------------------------------------------------
    // Frame position
    // ------------------------------------------------------------
    logic [8:0] cnt;
    logic [8:0] next_cnt;
    logic [8:0] eff_cnt;
    logic [2:0] bit_i;
    logic [5:0] islot;
    logic [4:0] oslot;
    logic out_act;
    logic in_done;

    // Frame sync restarts the count at bit 0 of slot 0
    always_comb begin
        eff_cnt = frame_sync ? `FBSM_CNT_RST : cnt;
        bit_i = eff_cnt[2:0];
        islot = eff_cnt[8:3];
        oslot = eff_cnt[7:3];
        out_act = ~eff_cnt[8];
        in_done = bit_tick && (bit_i == 3'h7);
        next_cnt = bit_tick ? eff_cnt + 9'h001 : cnt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= `FBSM_CNT_RST;
        end else begin
            cnt <= next_cnt;
        end
    end

    // ------------------------------------------------------------
    // Registers and APB slave
    // ------------------------------------------------------------
    fbsm_map_s in_map [64];
    fbsm_map_s out_map [64];
    fbsm_map_s next_in_map [64];
    fbsm_map_s next_out_map [64];
    logic [1:0] hiz;
    logic [1:0] next_hiz;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [15:0] idx;
    logic [5:0] widx;
    logic in_hit;
    logic out_hit;
    logic ro_hit;
    logic bad;
    logic req;
    logic done;
    logic [31:0] rdval;

    // Address decode and read mux
    always_comb begin
        idx = paddr[17:2];
        widx = paddr[7:2];
        in_hit = (idx & `FBSM_MAP_MASK) == `FBSM_IN_MAP_IDX;
        out_hit = (idx & `FBSM_MAP_MASK) == `FBSM_OUT_MAP_IDX;
        ro_hit = (idx == `FBSM_STAT_IDX) ||
                 ((idx & `FBSM_CHAN_MASK) == `FBSM_CHAN_IDX);
        rdval = 32'h0000_0000;
        bad = 1'b0;
        if (in_hit) begin
            rdval[7:0] = in_map[widx]; // see RULE_11
        end else if (out_hit) begin
            rdval[7:0] = out_map[widx]; // see RULE_04 see RULE_11
        end else if (idx == `FBSM_CTRL_IDX) begin
            rdval[1:0] = hiz;
        end else if (idx == `FBSM_STAT_IDX) begin
            rdval[8:0] = cnt;
        end else if ((idx & `FBSM_CHAN_MASK) == `FBSM_CHAN_IDX) begin
            rdval = in_chan[idx[3:0]];
        end else begin
            bad = 1'b1;
        end
        if (paddr[1:0] != 2'h0 || (pwrite && ro_hit)) begin
            bad = 1'b1;
        end
    end

    // One wait state, then the access completes with pready
    always_comb begin
        req = psel && penable;
        done = req && pready;
        next_pready = req && !pready;
        next_pslverr = req && !pready && bad;
        next_prdata = prdata;
        if (req && !pready && !pwrite) begin
            next_prdata = bad ? 32'h0000_0000 : rdval;
        end
        next_in_map = in_map;
        next_out_map = out_map;
        next_hiz = hiz;
        if (done && pwrite && !pslverr) begin
            if (in_hit) begin
                next_in_map[widx] = pwdata[7:0];
            end
            if (out_hit) begin
                next_out_map[widx] = pwdata[7:0];
            end
            if (idx == `FBSM_CTRL_IDX) begin
                next_hiz[`FBSM_HIZ_A_BIT] = pwdata[`FBSM_HIZ_A_BIT];
                next_hiz[`FBSM_HIZ_B_BIT] = pwdata[`FBSM_HIZ_B_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 64; i++) begin
                in_map[i] <= `FBSM_MAP_RST;
                out_map[i] <= `FBSM_MAP_RST; // see RULE_11
            end
            hiz <= `FBSM_CTRL_RST;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            in_map <= next_in_map;
            out_map <= next_out_map;
            hiz <= next_hiz;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------
    // Input slots
    // ------------------------------------------------------------
    logic [6:0] sh_a;
    logic [6:0] sh_b;
    logic [6:0] next_sh_a;
    logic [6:0] next_sh_b;
    fbsm_chan_t next_in_chan;
    fbsm_map_s ent_i;
    logic [7:0] wr_byte;
    logic [3:0] wr_ch;
    logic [1:0] wr_lane;

    // Shift both pins, then store the finished byte where mapped
    always_comb begin
        ent_i = in_map[islot];
        next_sh_a = bit_tick ? {sh_a[5:0], serial_in_pin_a} : sh_a;
        next_sh_b = bit_tick ? {sh_b[5:0], serial_in_pin_b} : sh_b;
        wr_byte = ent_i.grp ? {sh_b, serial_in_pin_b} // see RULE_12
                            : {sh_a, serial_in_pin_a};
        if (ent_i.rev) begin
            wr_byte = rev8(wr_byte);
        end
        wr_ch = chan_of(ent_i); // see RULE_01 see RULE_12
        wr_lane = ent_i.lane;
        next_in_chan = in_chan;
        if (in_done && ent_i.en) begin // see RULE_13
            next_in_chan[wr_ch][{~wr_lane, 3'b000} +: 8] = // see RULE_02
                wr_byte; // see RULE_03
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_a <= 7'h00;
            sh_b <= 7'h00;
            in_chan <= '0;
        end else begin
            sh_a <= next_sh_a;
            sh_b <= next_sh_b;
            in_chan <= next_in_chan;
        end
    end

    // ------------------------------------------------------------
    // Output slots
    // ------------------------------------------------------------
    fbsm_map_s ent_a;
    fbsm_map_s ent_b;
    logic [7:0] obyte_a;
    logic [7:0] obyte_b;
    fbsm_pin_s next_pin_a;
    fbsm_pin_s next_pin_b;

    // Pin a uses entries 0-31, pin b entries 32-63
    always_comb begin
        ent_a = out_map[{1'b0, oslot}]; // see RULE_05
        ent_b = out_map[{1'b1, oslot}]; // see RULE_05
        obyte_a = lane_of(out_chan[chan_of(ent_a)], // see RULE_06 see RULE_14
                          ent_a.lane); // see RULE_15
        obyte_b = lane_of(out_chan[chan_of(ent_b)], // see RULE_06 see RULE_14
                          ent_b.lane); // see RULE_15
        next_pin_a = serial_out_pin_a;
        next_pin_b = serial_out_pin_b;
        if (bit_tick) begin // see RULE_07 see RULE_08 see RULE_09 see RULE_10
            next_pin_a = pin_of(ent_a, out_act, hiz[`FBSM_HIZ_A_BIT],
                                obyte_a, bit_i);
            next_pin_b = pin_of(ent_b, out_act, hiz[`FBSM_HIZ_B_BIT],
                                obyte_b, bit_i);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out_pin_a <= '0;
            serial_out_pin_b <= '0;
        end else begin
            serial_out_pin_a <= next_pin_a;
            serial_out_pin_b <= next_pin_b;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic msb_a;
    logic lsb_a;
    logic en_b;
    logic map_hit;
    assign msb_a = obyte_a[3'h7 - bit_i];
    assign lsb_a = obyte_a[bit_i];
    assign en_b = out_map[{1'b1, oslot}].en;
    assign map_hit = in_hit || out_hit;

    sequence s_map_rd;
        psel && !penable && !pwrite && map_hit && paddr[1:0] == 2'h0
        ##1 psel && penable;
    endsequence

    a_in_lane_write: assert property ( // see RULE_02 see RULE_03
        in_done && ent_i.en |=> in_chan[$past(wr_ch)]
            [{~$past(wr_lane), 3'b000} +: 8] == $past(wr_byte))
        else $error("input byte not stored in mapped lane");
    a_in_pin_sel: assert property ( // see RULE_12 see RULE_01
        in_done && ent_i.en && ent_i.grp && !ent_i.rev
        |-> wr_byte == {sh_b, serial_in_pin_b} && wr_ch[3])
        else $error("pin b slot not routed to channels 40-47");
    a_in_disabled: assert property ( // see RULE_13
        in_done && !ent_i.en |=> in_chan == $past(in_chan))
        else $error("disabled input slot changed a channel");
    a_out_hiz: assert property ( // see RULE_07
        bit_tick && out_act && !ent_a.en && hiz[0]
        |=> !serial_out_pin_a.oe)
        else $error("disabled slot drove pin a in idle hiz mode");
    a_out_low: assert property ( // see RULE_08
        bit_tick && out_act && !ent_a.en && !hiz[0]
        |=> serial_out_pin_a.oe && !serial_out_pin_a.dout)
        else $error("disabled slot did not drive pin a low");
    a_out_msb: assert property ( // see RULE_09 see RULE_15
        bit_tick && out_act && ent_a.en && !ent_a.rev
        |=> serial_out_pin_a.oe && serial_out_pin_a.dout == $past(msb_a))
        else $error("pin a bit not sent msb first");
    a_out_lsb: assert property ( // see RULE_10
        bit_tick && out_act && ent_a.en && ent_a.rev
        |=> serial_out_pin_a.dout == $past(lsb_a))
        else $error("reversed slot not sent lsb first");
    a_pin_b_entry: assert property ( // see RULE_05
        bit_tick && out_act
        |=> serial_out_pin_b.oe == ($past(en_b) || !$past(hiz[1])))
        else $error("pin b not governed by entries 32-63");
    a_map_rsvd_zero: assert property ( // see RULE_11 see RULE_04
        s_map_rd |=> pready && prdata[31:8] == 24'h0)
        else $error("map read late or reserved bits nonzero");
    a_map_write: assert property ( // see RULE_04
        done && pwrite && !pslverr && out_hit
        |=> out_map[$past(widx)] == $past(pwdata[7:0]))
        else $error("output map write lost");

endmodule // fbsm_slot_mapper

// [bench/fbsm_tdm_peer.sv]
// Far-side TDM device model: sends input frames, records output pins
module fbsm_tdm_peer (
    input wire logic pclk, // Shared clock
    input wire logic go, // Start one frame
    output logic bit_tick, // One bit per cycle inside a frame
    output logic frame_sync, // Marks bit 0 of slot 0
    output logic serial_in_pin_a, // Stream into pin a
    output logic serial_in_pin_b, // Stream into pin b
    input wire fbsm_pkg::fbsm_pin_s serial_out_pin_a, // Pin a seen
    input wire fbsm_pkg::fbsm_pin_s serial_out_pin_b // Pin b seen
);
    import fbsm_pkg::*;
    logic [7:0] tx_a [64];
    logic [7:0] tx_b [64];
    fbsm_pin_s cap_a [256];
    fbsm_pin_s cap_b [256];
    int p = 512;

    // ----------------------------------------
    // Frame engine
    // ----------------------------------------
    initial begin
        bit_tick = 1'b0;
        frame_sync = 1'b0;
        serial_in_pin_a = 1'b0;
        serial_in_pin_b = 1'b1;
    end
    // Pin value of bit q shows two edges after it is driven
    always @(posedge pclk) begin
        if (p >= 2 && p <= 257) begin
            cap_a[p - 2] <= serial_out_pin_a;
            cap_b[p - 2] <= serial_out_pin_b;
        end
        if (p < 512) begin
            bit_tick <= 1'b1;
            frame_sync <= (p == 0);
            serial_in_pin_a <= tx_a[p / 8][7 - p % 8]; // MSB first
            serial_in_pin_b <= tx_b[p / 8][7 - p % 8];
            p <= p + 1;
        end else begin
            // Idle: clock stands, data lines carry junk
            bit_tick <= 1'b0;
            frame_sync <= 1'b0;
            serial_in_pin_a <= ~serial_in_pin_a;
            serial_in_pin_b <= ~serial_in_pin_b;
        end
        if (go) begin
            p <= 0;
        end
    end
endmodule // fbsm_tdm_peer

// [bench/flexible_tdm_byte_slot_mapper_bench.sv]
// Self-checking bench for the flexible TDM byte slot mapper
`include "fbsm_params.svh"

module flexible_tdm_byte_slot_mapper_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import fbsm_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic go = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, bit_tick, frame_sync, sin_a, sin_b, er;
    fbsm_chan_t out_chan = '0;
    fbsm_chan_t in_chan;
    fbsm_pin_s pin_a, pin_b;
    fbsm_map_s m;
    fbsm_map_s om [64];
    logic [31:0] exp_ch [16];
    logic [7:0] bt;
    int err_count = 0;
    int tests_run = 0;

    always #25 pclk = ~pclk;

    fbsm_slot_mapper fbsm_slot_mapper_i (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bit_tick(bit_tick), .frame_sync(frame_sync),
        .serial_in_pin_a(sin_a), .serial_in_pin_b(sin_b),
        .out_chan(out_chan), .in_chan(in_chan),
        .serial_out_pin_a(pin_a), .serial_out_pin_b(pin_b));
    fbsm_tdm_peer fbsm_tdm_peer_i (.pclk(pclk), .go(go),
        .bit_tick(bit_tick), .frame_sync(frame_sync),
        .serial_in_pin_a(sin_a), .serial_in_pin_b(sin_b),
        .serial_out_pin_a(pin_a), .serial_out_pin_b(pin_b));

    // ----------------------------------------
    // Report and compare tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] ex);
        tests_run++;
        if (got !== ex) begin
            err_count++;
            $display("[FAIL] %0t word %h expected %h", $time, got, ex);
        end
    endtask
    // A released pin only has its enable compared
    task automatic chk_pin(input fbsm_pin_s got, input fbsm_pin_s ex);
        tests_run++;
        if (got.oe !== ex.oe || (ex.oe && got.dout !== ex.dout)) begin
            err_count++;
            $display("[FAIL] %0t pin %b expected %b", $time, got, ex);
        end
    endtask
    // One APB transfer; holds the request until pready is seen
    task automatic apb(input logic wr, input logic [15:0] idx,
                       input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_count++;
            $display("[FAIL] %0t bus transfer never completed", $time);
            tally_and_finish();
        end
        @(posedge pclk);
    endtask
    function automatic fbsm_pin_s exp_pin(input fbsm_map_s e, input int k,
                                          input logic hiz);
        logic [7:0] b;
        b = out_chan[{e.grp, e.pos}][8 * (3 - e.lane) +: 8];
        if (e.en) begin
            return '{dout: e.rev ? b[k] : b[7 - k], oe: 1'b1};
        end
        return '{dout: 1'b0, oe: !hiz};
    endfunction
    task automatic run_frame();
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (520) @(posedge pclk);
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values of output entry 63 and input entry 0
        apb(1'b0, `FBSM_OUT_MAP_IDX + 16'h003f, 32'h00000000);
        chk_word(rd, 32'h00000000);
        apb(1'b0, `FBSM_IN_MAP_IDX, 32'h00000000);
        chk_word(rd, 32'h00000000);
        $display("test reset done");
        // Readback, refused write and unmapped read
        apb(1'b1, `FBSM_OUT_MAP_IDX + 16'h0005, 32'h00000085);
        apb(1'b0, `FBSM_OUT_MAP_IDX + 16'h0005, 32'h00000000);
        chk_word(rd, 32'h00000085);
        apb(1'b1, `FBSM_STAT_IDX, 32'h00000001);
        chk_word({31'h0, er}, 32'h00000001);
        apb(1'b0, 16'h0100, 32'h00000000);
        chk_word({31'h0, er}, 32'h00000001);
        $display("test registers done");
        // Input: every channel byte lane, one slot disabled
        for (int s = 0; s < 64; s++) begin
            fbsm_tdm_peer_i.tx_a[s] = 8'(s * 37 + 17);
            fbsm_tdm_peer_i.tx_b[s] = 8'(s * 91 + 3);
            m = '{en: s != 9, rev: s % 7 == 3, grp: s >= 32,
                  pos: 3'(s / 4), lane: 2'(s)};
            apb(1'b1, `FBSM_IN_MAP_IDX + 16'(s), {24'h000000, m});
            if (s == 0 || s == 32) exp_ch[{m.grp, 3'h0}] = 32'h00000000;
            if (s % 4 == 0 && s % 32 != 0) exp_ch[{m.grp, m.pos}] = '0;
            // Byte as sent, mirrored when the entry asks for LSB first
            bt = m.grp ? fbsm_tdm_peer_i.tx_b[s] : fbsm_tdm_peer_i.tx_a[s];
            if (m.rev) begin
                bt = {<<{bt}};
            end
            if (m.en) begin
                exp_ch[{m.grp, m.pos}][8 * (3 - m.lane) +: 8] = bt;
            end
        end
        run_frame();
        for (int c = 0; c < 16; c++) begin
            chk_word(in_chan[c],
                     exp_ch[c]);
        end
        $display("test input mapping done");
        // Output: all 64 entries, each idle mode on each pin
        for (int n = 0; n < 16; n++) begin
            out_chan[n] <= 32'(n) * 32'h01020408 + 32'h80402010;
        end
        for (int s = 0; s < 64; s++) begin
            om[s] = '{en: s % 5 != 4, rev: s % 3 == 0, grp: 1'(s),
                      pos: 3'(s / 2), lane: 2'(s / 16)};
            apb(1'b1, `FBSM_OUT_MAP_IDX + 16'(s), {24'h000000, om[s]});
        end
        for (int h = 1; h <= 2; h++) begin
            apb(1'b1, `FBSM_CTRL_IDX, 32'(h));
            run_frame();
            for (int p = 0; p < 256; p++) begin
                chk_pin(fbsm_tdm_peer_i.cap_a[p],
                    exp_pin(om[p / 8], p % 8,
                    h[0]));
                chk_pin(fbsm_tdm_peer_i.cap_b[p],
                    exp_pin(om[32 + p / 8], p % 8,
                    h[1]));
            end
            $display("test output mapping pass %0d done", h);
        end
        tally_and_finish();
    end
endmodule // flexible_tdm_byte_slot_mapper_bench
